// ==== mpfs_bal_if.sv ====
// Interface that carries channel samples and balance corrections.
`timescale 1ns/1ps
interface mpfs_bal_if;
   import mpfs_pkg::*;
   // Per-channel current samples.
   logic [CUR_W-1:0]        sample  [NCH];
   // Active channel mask.
   logic [NCH-1:0]          active;
   // Average of the active channels.
   logic [CUR_W-1:0]        average;
   // Signed pulse-width corrections.
   logic signed [ERR_W-1:0] corr    [NCH];

   modport core (output sample, output active, input average, input corr);
   modport bal  (input sample, input active, output average, output corr);
endinterface : mpfs_bal_if

// ==== mpfs_balance.sv ====
// Channel current averaging and balance error module.
`timescale 1ns/1ps
module mpfs_balance
(
   // Clock and reset.
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Sample and correction carrier.
   mpfs_bal_if.bal   bus
);
   import mpfs_pkg::*;

   // Sum of active samples and count of active channels.
   logic [CUR_W+1:0] sum;
   logic [2:0]       cnt;

   // Adds the active samples; inactive channels do not weigh in.
   always_comb
   begin
      sum = '0;
      cnt = '0;
      for (int i = 0; i < NCH; i++)
      begin
         if (bus.active[i])
         begin
            sum = sum + {2'b00, bus.sample[i]};
            cnt = cnt + 3'h1;
         end
      end
   end

   // The average is registered; a divide by 1..4 is cheap at this width.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bus.average <= '0;
      else if (cnt != 3'h0)
         bus.average <= CUR_W'(sum / {9'h000, cnt});
      else
         bus.average <= '0;
   end

   // Each active channel's correction is average minus its own sample, so a low channel widens; an inactive channel gets zero.
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_err
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               bus.corr[g] <= '0;
            else if (bus.active[g])
               bus.corr[g] <= $signed({1'b0, bus.average}) - $signed({1'b0, bus.sample[g]});
            else
               bus.corr[g] <= '0;
         end
      end
   endgenerate

endmodule : mpfs_balance

// ==== mpfs_gate_drv.sv ====
// Behavioural model of the external gate drivers that read the PWM pins.
`timescale 1ns/1ps
module mpfs_gate_drv
(
   // Pins from the controller.
   input  wire logic [3:0] pwm_i,
   input  wire logic [3:0] pwm_oe_i,
   // Switch states of each channel.
   output logic      [3:0] upper_on_o,
   output logic      [3:0] lower_on_o
);
   // A floating pin turns both switches off, so only a driven high turns the upper switch on.
   assign upper_on_o = pwm_oe_i & pwm_i;
   // A driven low turns the lower switch on and clamps the output.
   assign lower_on_o = pwm_oe_i & ~pwm_i;
endmodule // mpfs_gate_drv

// ==== mpfs_pkg.sv ====
// Package of constants and types for the multiphase fault and enable sequencer.
package mpfs_pkg;

   // Width of the voltage code input.
   localparam int unsigned VCODE_W = 5;
   // Code that signals a no-load condition.
   localparam logic [4:0] VCODE_OFF = 5'h1f;
   // Reference level in millivolts for the all-zeros code.
   localparam logic [10:0] REF_MV_MAX = 11'h73a;
   // Reference step in millivolts per unit of the code.
   localparam logic [10:0] REF_MV_STEP = 11'h019;
   // Width of the reference level output in millivolts.
   localparam int unsigned REF_W = 11;

   // Width of the soft-start and hiccup counters.
   localparam int unsigned SS_W = 11;
   // Last count of an 11-bit counter; a full run spans 2048 phase clocks.
   localparam logic [10:0] SS_LAST = 11'h7ff;
   // Reset value of the soft-start counter.
   localparam logic [10:0] SS_RST = 11'h000;

   // Width of a channel current sample and number of channels.
   localparam int unsigned CUR_W = 10;
   localparam int unsigned NCH = 4;
   // Width of the signed balance correction.
   localparam int unsigned ERR_W = 11;

   // Drive codes of one PWM pin.
   typedef enum logic [1:0]
   {
      MPFS_DRV_HIZ  = 2'b00,
      MPFS_DRV_LOW  = 2'b01,
      MPFS_DRV_RUN  = 2'b10
   } mpfs_drv_t;

   // Sequencer states.
   typedef enum logic [2:0]
   {
      MPFS_ST_OFF   = 3'b000,
      MPFS_ST_SOFT  = 3'b001,
      MPFS_ST_RUN   = 3'b010,
      MPFS_ST_HICC  = 3'b011,
      MPFS_ST_OVLO  = 3'b100,
      MPFS_ST_OVHZ  = 3'b101
   } mpfs_state_t;

endpackage : mpfs_pkg

// ==== mpfs_sequencer.sv ====
// Top of the multiphase fault and enable sequencer.
`timescale 1ns/1ps
// How it works
// - Balance each channel toward the active average.
// - Average over 75 uA reference shuts down.
// - Overcurrent shutdown floats every PWM output.
// - Wait 2048 phase clocks, then soft-start.
// - Retry forever until a soft-start succeeds.
// - Code zero gives 1.850, steps 25 mV.
// - All-ones code means shutdown, others restart.
// - Output above 2.1 V drives PWM low.
// - Back at reference level, PWM floats.
// - Each overvoltage recurrence drives low again.
// - Overvoltage latches until supply power cycle.
// - No supply-ok holds outputs floating.
// - Stay shut down until enable above 1.23V.
// - All start conditions true begin soft-start.
// - Soft-start counts 2048 phase clocks.
// - Cycle starts when phase 1 terminates.
module mpfs_sequencer
   import mpfs_pkg::*;
(
   // Clock and reset.
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   // Comparator results from the analog side.
   input  wire logic                     supply_ok_i,
   input  wire logic                     enable_above_i,
   input  wire logic                     overcurrent_i,
   input  wire logic                     overvoltage_i,
   input  wire logic                     at_reference_i,
   // Phase clock tick, same domain, and voltage code pins.
   input  wire logic                     phase_tick_i,
   input  wire logic [mpfs_pkg::VCODE_W-1:0] voltage_code_i,
   // Channel current samples and active channel mask.
   input  wire logic [mpfs_pkg::CUR_W-1:0]   sample0_i,
   input  wire logic [mpfs_pkg::CUR_W-1:0]   sample1_i,
   input  wire logic [mpfs_pkg::CUR_W-1:0]   sample2_i,
   input  wire logic [mpfs_pkg::CUR_W-1:0]   sample3_i,
   input  wire logic [mpfs_pkg::NCH-1:0]     active_i,
   // Pulse width commands from the modulator, one per channel.
   input  wire logic [mpfs_pkg::NCH-1:0]     pwm_cmd_i,
   // PWM pins: value and output enable.
   output logic [mpfs_pkg::NCH-1:0]          pwm_o,
   output logic [mpfs_pkg::NCH-1:0]          pwm_oe_o,
   // Status and analog-facing outputs.
   output logic [mpfs_pkg::REF_W-1:0]        reference_level_o,
   output logic [mpfs_pkg::CUR_W-1:0]        average_channel_current_o,
   output logic [mpfs_pkg::ERR_W*mpfs_pkg::NCH-1:0] balance_error_o,
   output logic                              soft_start_o,
   output logic [mpfs_pkg::SS_W-1:0]         soft_count_o,
   output logic                              cycle_start_o,
   output logic [2:0]                        state_o
);
   import mpfs_pkg::*;

   // Two-stage synchronisers for the asynchronous comparator and pin inputs.
   logic [4:0]         meta_q;
   logic [4:0]         sync_q;
   logic [VCODE_W-1:0] code_meta_q;
   logic [VCODE_W-1:0] code_q;
   logic               sok;
   logic               en;
   logic               oc;
   logic               ov;
   logic               atref;

   // Only the second stage is read by logic.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q      <= '0;
         sync_q      <= '0;
         code_meta_q <= VCODE_OFF;
         code_q      <= VCODE_OFF;
      end
      else
      begin
         meta_q      <= {at_reference_i, overvoltage_i, overcurrent_i, enable_above_i, supply_ok_i};
         sync_q      <= meta_q;
         code_meta_q <= voltage_code_i;
         code_q      <= code_meta_q;
      end
   end

   assign sok   = sync_q[0];
   assign en    = sync_q[1];
   assign oc    = sync_q[2];
   assign ov    = sync_q[3];
   assign atref = sync_q[4];

   // Start conditions all true at once.
   logic code_ok;
   logic start_ok;
   assign code_ok  = (code_q != VCODE_OFF);
   assign start_ok = sok && en && code_ok;

   // Reference level: 1850 mV minus 25 mV per unit of code.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reference_level_o <= '0;
      else if (code_ok)
         reference_level_o <= REF_W'(REF_MV_MAX - REF_W'(REF_MV_STEP * {6'h00, code_q}));
      else
         reference_level_o <= '0; // Off code selects no reference.
   end

   // Channel balance block shares its signals over the interface.
   mpfs_bal_if bal_if ();
   assign bal_if.sample[0] = sample0_i;
   assign bal_if.sample[1] = sample1_i;
   assign bal_if.sample[2] = sample2_i;
   assign bal_if.sample[3] = sample3_i;
   assign bal_if.active    = active_i;

   mpfs_balance u_bal
   (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .bus     (bal_if.bal)
   );

   assign average_channel_current_o = bal_if.average;
   genvar gc;
   generate
      for (gc = 0; gc < NCH; gc++)
      begin : g_err_out
         assign balance_error_o[gc*ERR_W +: ERR_W] = bal_if.corr[gc];
      end
   endgenerate

   // State register and the shared 11-bit phase counter.
   mpfs_state_t state_q;
   mpfs_state_t state_d;
   logic [SS_W-1:0] cnt_q;
   logic            cnt_done;
   logic            ov_latch_q;
   assign cnt_done = phase_tick_i && (cnt_q == SS_LAST);

   // Next-state logic; supply loss outranks everything, overvoltage outranks the rest.
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         MPFS_ST_OFF:
            if (start_ok && !ov_latch_q)
               state_d = MPFS_ST_SOFT;
         MPFS_ST_SOFT:
            if (oc)
               state_d = MPFS_ST_HICC;
            else if (cnt_done)
               state_d = MPFS_ST_RUN;
         MPFS_ST_RUN:
            if (oc)
               state_d = MPFS_ST_HICC;
         MPFS_ST_HICC:
            if (cnt_done)
               state_d = MPFS_ST_SOFT;
         MPFS_ST_OVLO:
            if (atref && !ov)
               state_d = MPFS_ST_OVHZ;
         MPFS_ST_OVHZ:
            if (ov)
               state_d = MPFS_ST_OVLO;
         default:
            state_d = MPFS_ST_OFF;
      endcase
      if (state_q != MPFS_ST_OVLO && state_q != MPFS_ST_OVHZ)
      begin
         if (!sok || !en || !code_ok)
            state_d = MPFS_ST_OFF;
         if (ov && sok)
            state_d = MPFS_ST_OVLO;
      end
      else if (!sok)
         state_d = MPFS_ST_OFF;
   end

   // State register update.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_q <= MPFS_ST_OFF;
      else
         state_q <= state_d;
   end

   // Overvoltage latch clears only when supply-ok drops, so a power cycle is needed.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ov_latch_q <= 1'b0;
      else if (ov && sok)
         ov_latch_q <= 1'b1;
      else if (!sok)
         ov_latch_q <= 1'b0;
   end

   // Counter restarts on every state change and advances once per phase tick in soft-start and hiccup.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_q <= SS_RST;
      else if (state_d != state_q)
         cnt_q <= SS_RST;
      else if ((state_q == MPFS_ST_SOFT || state_q == MPFS_ST_HICC) && phase_tick_i)
         cnt_q <= cnt_q + 11'h001;
   end

   // Cycle start pulse: a phase tick during switching terminates phase 1.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cycle_start_o <= 1'b0;
      else
         cycle_start_o <= phase_tick_i && (state_q == MPFS_ST_RUN || state_q == MPFS_ST_SOFT);
   end

   // PWM pin drive, registered; floating is output enable low.
   genvar gp;
   generate
      for (gp = 0; gp < NCH; gp++)
      begin : g_pwm
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               pwm_o[gp]    <= 1'b0;
               pwm_oe_o[gp] <= 1'b0;
            end
            else
            begin
               unique case (state_d)
                  MPFS_ST_OVLO:
                  begin
                     pwm_o[gp]    <= 1'b0;
                     pwm_oe_o[gp] <= 1'b1;
                  end
                  MPFS_ST_SOFT, MPFS_ST_RUN:
                  begin
                     // Phase 1 is forced low on the cycle-start tick.
                     pwm_o[gp]    <= pwm_cmd_i[gp] && !(gp == 0 && phase_tick_i);
                     pwm_oe_o[gp] <= active_i[gp];
                  end
                  default:
                  begin
                     pwm_o[gp]    <= 1'b0;
                     pwm_oe_o[gp] <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

   assign soft_start_o = (state_q == MPFS_ST_SOFT);
   assign soft_count_o = cnt_q;
   assign state_o      = state_q;

   // Assertions guarding the sequencing.
   // The pins follow state_d on the same edge as state_q, so they match state_q in the same cycle.
   a_oc_floats: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == MPFS_ST_HICC) |-> (pwm_oe_o == '0))
      else $error("PWM driven during hiccup wait");
   a_hicc_to_soft: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == MPFS_ST_HICC && cnt_done && sok && en && code_ok && !ov) |=> (state_q == MPFS_ST_SOFT))
      else $error("Hiccup wait did not end in soft-start");
   a_oc_trip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == MPFS_ST_RUN && oc && sok && en && code_ok && !ov) |=> (state_q == MPFS_ST_HICC))
      else $error("Overcurrent did not shut down");
   a_soft_fail: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == MPFS_ST_SOFT && oc && sok && en && code_ok && !ov) |=> (state_q == MPFS_ST_HICC))
      else $error("Soft-start trip not treated as failure");
   a_ov_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (ov && sok) |=> (pwm_oe_o == '1 && pwm_o == '0))
      else $error("Overvoltage did not force outputs low");
   a_ov_latched: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (ov_latch_q && sok) |-> (state_q != MPFS_ST_RUN && state_q != MPFS_ST_SOFT))
      else $error("Normal operation after overvoltage");
   a_nosupply_hiz: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!sok) [*2] |=> (pwm_oe_o == '0))
      else $error("Outputs driven without supply-ok");
   a_start_now: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == MPFS_ST_OFF && start_ok && !ov_latch_q && !ov) |=> (state_q == MPFS_ST_SOFT))
      else $error("Start-up delayed");
   a_off_code: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (code_q == VCODE_OFF && !ov_latch_q && !ov) |=> (state_q == MPFS_ST_OFF))
      else $error("All-ones code did not shut down");
   a_ref_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ($stable(code_q) && code_q == 5'h1e) |=> (reference_level_o == 11'h44c))
      else $error("Reference decode wrong");

   c_soft_done: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      state_q == MPFS_ST_SOFT ##1 state_q == MPFS_ST_RUN);
   c_hiccup: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      state_q == MPFS_ST_HICC ##1 state_q == MPFS_ST_SOFT);
   c_ov_cycle: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      state_q == MPFS_ST_OVHZ ##1 state_q == MPFS_ST_OVLO);

endmodule : mpfs_sequencer

// ==== tb_top.sv ====
// Self-checking testbench of the multiphase fault and enable sequencer.
`timescale 1ns/1ps
module tb_top;
   import mpfs_pkg::*;
   // Cycle ceiling; the longest path holds four waits of 2048 ticks.
   localparam int LIMIT = 20000;
   logic        clock_i, rst_n_i, supply_ok_i, enable_above_i;
   logic        overcurrent_i, overvoltage_i, at_reference_i, phase_tick_i;
   logic [4:0]  voltage_code_i;
   logic [9:0]  smp [4];
   logic [3:0]  active_i, pwm_cmd_i, pwm_o, pwm_oe_o, upper_on, lower_on;
   logic [10:0] reference_level_o, soft_count_o;
   logic [9:0]  average_channel_current_o;
   logic [43:0] balance_error_o;
   logic        soft_start_o, cycle_start_o;
   logic [2:0]  state_o;
   int          num_errors = 0;
   int          checked = 0;
   int          cyc = 0;

   mpfs_sequencer i_dut
   (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i), .enable_above_i(enable_above_i),
      .overcurrent_i(overcurrent_i), .overvoltage_i(overvoltage_i), .at_reference_i(at_reference_i),
      .phase_tick_i(phase_tick_i), .voltage_code_i(voltage_code_i), .sample0_i(smp[0]), .sample1_i(smp[1]),
      .sample2_i(smp[2]), .sample3_i(smp[3]), .active_i(active_i), .pwm_cmd_i(pwm_cmd_i), .pwm_o(pwm_o),
      .pwm_oe_o(pwm_oe_o), .reference_level_o(reference_level_o),
      .average_channel_current_o(average_channel_current_o), .balance_error_o(balance_error_o),
      .soft_start_o(soft_start_o), .soft_count_o(soft_count_o), .cycle_start_o(cycle_start_o), .state_o(state_o)
   );

   // Far side: the gate drivers.
   mpfs_gate_drv i_drv (.pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o), .upper_on_o(upper_on), .lower_on_o(lower_on));

   // Free-running 100 MHz clock.
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Cuts a hang short and counts it as a mismatch.
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: bench timed out", $time);
         conclude();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("TB: checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Compares one observed value with its expected value.
   task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // Lets n edges pass and samples after their updates have landed.
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // Drives all comparator levels and the code on one rising edge.
   task automatic setin(input logic s, e, oc, ov, ar, input logic [4:0] code);
      @(posedge clock_i);
      supply_ok_i <= s;
      enable_above_i <= e;
      overcurrent_i <= oc;
      overvoltage_i <= ov;
      at_reference_i <= ar;
      voltage_code_i <= code;
   endtask

   // Waits a bounded number of cycles for a state, then compares it.
   task automatic wait_st(input logic [2:0] s, input int max);
      step(1);
      for (int i = 0; i < max && state_o !== s; i++)
         step(1);
      chk("state", state_o, s);
   endtask

   // Counts the cycles for which a state is held.
   task automatic len_st(input logic [2:0] s, output int n);
      n = 0;
      while (state_o === s && n < 4000)
      begin
         n++;
         step(1);
      end
   endtask

   // Walks every voltage code while the supply is down.
   task automatic t_decode();
      for (int c = 0; c < 32; c++)
      begin
         setin(0, 0, 0, 0, 0, 5'(c));
         step(4);
         chk("ref", reference_level_o, (c == 31) ? 48'h0 : 48'(REF_MV_MAX) - 48'(c) * 48'(REF_MV_STEP));
      end
      $display("TB: decode test done");
   endtask

   // Start-up gating, no-load code and soft-start length.
   task automatic t_gate();
      int n;
      setin(1, 0, 0, 0, 0, 5'h0a);
      step(8);
      chk("no enable", {state_o, pwm_oe_o}, 7'h00);
      setin(1, 1, 0, 0, 0, 5'h1f);
      step(8);
      chk("off code", state_o, 3'h0);
      setin(0, 1, 0, 0, 0, 5'h0a);
      step(8);
      chk("no supply", {state_o, pwm_oe_o}, 7'h00);
      setin(1, 1, 0, 0, 0, 5'h0a);
      wait_st(3'h1, 3);
      chk("soft flag", soft_start_o, 1'b1);
      step(9);
      chk("count", soft_count_o, 11'h009);
      setin(1, 1, 0, 0, 0, 5'h1f);
      wait_st(3'h0, 3);
      setin(1, 1, 0, 0, 0, 5'h0a);
      wait_st(3'h1, 3);
      len_st(3'h1, n);
      chk("soft len", n, 2048);
      chk("run", state_o, 3'h2);
      chk("drive hi", upper_on, pwm_cmd_i & 4'he);
      chk("drive lo", lower_on, 4'(~(pwm_cmd_i & 4'he)));
      chk("cycle", cycle_start_o, 1'b1);
      $display("TB: gate test done");
   endtask

   // Overcurrent shutdown, a failed retry, then recovery.
   task automatic t_hiccup();
      int n;
      setin(1, 1, 1, 0, 0, 5'h0a);
      step(1);
      chk("sync hold", state_o, 3'h2);
      wait_st(3'h3, 3);
      chk("float", {upper_on, lower_on, pwm_oe_o}, 12'h000);
      len_st(3'h3, n);
      chk("wait len", n, 2048);
      chk("retry", state_o, 3'h1);
      chk("no cycle", cycle_start_o, 1'b0);
      wait_st(3'h3, 4);
      setin(1, 1, 0, 0, 0, 5'h0a);
      wait_st(3'h1, 2100);
      len_st(3'h1, n);
      chk("recovered", state_o, 3'h2);
      $display("TB: hiccup test done");
   endtask

   // Average over three active channels and their corrections.
   task automatic t_balance();
      @(posedge clock_i);
      active_i <= 4'h7;
      smp <= '{10'h064, 10'h0c8, 10'h12c, 10'h3e7};
      step(4);
      chk("avg", average_channel_current_o, 10'h0c8);
      chk("err", balance_error_o, {11'h000, 11'h79c, 11'h000, 11'h064});
      chk("oe mask", pwm_oe_o, 4'h7);
      // Four channels divide by four; with no tick phase 1 follows its command.
      @(posedge clock_i);
      active_i <= 4'hf;
      phase_tick_i <= 1'b0;
      step(2);
      chk("avg4", average_channel_current_o, 10'h18f);
      chk("tick off", {upper_on, cycle_start_o}, 5'h0a);
      @(posedge clock_i);
      phase_tick_i <= 1'b1;
      $display("TB: balance test done");
   endtask

   // Overvoltage clamp, float, recurrence and the supply-cycle latch.
   task automatic t_ovp();
      setin(1, 1, 0, 1, 0, 5'h0a);
      wait_st(3'h4, 3);
      chk("ov low", {pwm_oe_o, pwm_o, lower_on}, 12'hf0f);
      setin(1, 1, 0, 0, 1, 5'h0a);
      wait_st(3'h5, 3);
      chk("ov float", {pwm_oe_o, upper_on, lower_on}, 12'h000);
      setin(1, 1, 0, 1, 0, 5'h0a);
      wait_st(3'h4, 3);
      setin(1, 0, 0, 0, 1, 5'h1f);
      step(8);
      chk("latched", state_o, 3'h5);
      setin(1, 1, 0, 0, 1, 5'h0a);
      step(8);
      chk("no restart", state_o, 3'h5);
      setin(0, 1, 0, 0, 0, 5'h0a);
      wait_st(3'h0, 3);
      setin(1, 1, 0, 0, 0, 5'h0a);
      wait_st(3'h1, 3);
      $display("TB: overvoltage test done");
   endtask

   // Main sequence; the tick runs every clock so the 2048 counts stay short.
   initial
   begin
      rst_n_i = 1'b0;
      {supply_ok_i, enable_above_i, overcurrent_i, overvoltage_i, at_reference_i} = 5'h00;
      phase_tick_i = 1'b1;
      voltage_code_i = 5'h1f;
      active_i = 4'hf;
      pwm_cmd_i = 4'h5;
      smp = '{default: 10'h000};
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_decode();
      t_gate();
      t_hiccup();
      t_balance();
      t_ovp();
      conclude();
   end
endmodule // tb_top
